/* design/dwd_regs.vh */
// constants for the dac write word decoder
`ifndef DWD_REGS_VH
`define DWD_REGS_VH
`define DWD_DATA_W       14
`define DWD_ADDR_W       8
`define DWD_CHAN_N       32
`define DWD_SLOT_N       8
`define DWD_GROUP_N      4
`define DWD_SEL_INPUT    2'h3
`define DWD_SEL_OFFSET   2'h2
`define DWD_SEL_GAIN     2'h1
`define DWD_SEL_SPECIAL  2'h0
`define DWD_SOFT_RESET   14'h3FFF
`define DWD_INPUT_RST    14'h0000
`define DWD_OFFSET_RST   14'h2000
`define DWD_GAIN_RST     14'h3FFF
`define DWD_FULL_SCALE   15'h3FFF
`define DWD_STEP_LSB     0
`define DWD_STEP_MSB     6
`define DWD_DIR_BIT      8
`define DWD_GRP_LSB      4
`define DWD_GRP_MSB      7
`define DWD_SLOT_MSB     3
`define DWD_FRAME_W      24
`define DWD_SER_ADDR_LSB 16
`define DWD_SER_SEL_LSB  14
`endif

/* design/dwd_addr_decode.v */
// group and slot address decode into a 32-channel write mask
`include "dwd_regs.vh"
module dwd_addr_decode
(
    // address in
    input  wire [`DWD_ADDR_W-1:0] i_addr,
    // channel mask out
    output reg  [`DWD_CHAN_N-1:0] o_chan_mask
);
    reg [2:0] slot;
    reg       slot_ok;
    integer   g;
    always @*
    begin
        slot    = 3'h0;
        slot_ok = 1'b1;
        case (i_addr[`DWD_SLOT_MSB:0])
            4'h0: slot = 3'h0;
            4'h1: slot = 3'h1;
            4'h2: slot = 3'h2;
            4'h3: slot = 3'h3;
            4'h4: slot = 3'h4;
            4'h5: slot = 3'h5;
            4'h8: slot = 3'h6;
            4'h9: slot = 3'h7;
            default: slot_ok = 1'b0;
        endcase
        o_chan_mask = {`DWD_CHAN_N{1'b0}};
        if (i_addr[`DWD_GRP_MSB:`DWD_GRP_LSB] == 4'h0)
        begin
            o_chan_mask = {`DWD_CHAN_N{1'b1}};
        end
        else if (slot_ok)
        begin
            for (g = 0; g < `DWD_GROUP_N; g = g + 1)
            begin
                if (i_addr[`DWD_GRP_LSB + g])
                    o_chan_mask[g * `DWD_SLOT_N + slot] = 1'b1;
            end
        end
    end
endmodule

/* design/dwd_decoder.v */
// dac write word decoder: one write word to per-channel code registers
`include "dwd_regs.vh"
module dwd_decoder
#(
    parameter DATA_W = `DWD_DATA_W,
    parameter CHAN_N = `DWD_CHAN_N
)
(
    // clock and reset
    input  wire                    i_clk,
    input  wire                    i_reset_n,
    // parallel write word
    input  wire                    i_wr_valid,
    input  wire [`DWD_ADDR_W-1:0]  i_write_address_bits,
    input  wire                    i_reg_select_hi,
    input  wire                    i_reg_select_lo,
    input  wire [DATA_W-1:0]       i_write_data_bits,
    // serial word alternative
    input  wire                    i_ser_valid,
    input  wire [`DWD_FRAME_W-1:0] i_ser_frame,
    // read back of one channel
    input  wire [4:0]              i_rd_chan,
    output reg  [DATA_W-1:0]       o_channel_input_code,
    output reg  [DATA_W-1:0]       o_offset_code,
    output reg  [DATA_W-1:0]       o_gain_code,
    output reg  [DATA_W-1:0]       o_derived_channel_code,
    // write strobes toward the rest of the device
    output reg  [CHAN_N-1:0]       o_input_wr,
    output reg  [CHAN_N-1:0]       o_offset_wr,
    output reg  [CHAN_N-1:0]       o_gain_wr,
    output reg                     o_soft_reset,
    output reg                     o_reference_ground
);
    reg  [DATA_W-1:0] input_q  [0:CHAN_N-1];
    reg  [DATA_W-1:0] offset_q [0:CHAN_N-1];
    reg  [DATA_W-1:0] gain_q   [0:CHAN_N-1];
    reg  [DATA_W-1:0] derived_q[0:CHAN_N-1];
    reg               wv;
    reg  [7:0]        addr;
    reg  [1:0]        sel;
    reg  [DATA_W-1:0] data;
    wire [CHAN_N-1:0] mask;
    wire              is_reset;
    wire              is_step;
    integer           c;

    // serial frame unpacked msb first; serial wins if both arrive
    always @*
    begin
        wv   = i_wr_valid | i_ser_valid;
        addr = i_write_address_bits;
        sel  = {i_reg_select_hi, i_reg_select_lo};
        data = i_write_data_bits;
        if (i_ser_valid)
        begin
            addr = i_ser_frame[`DWD_FRAME_W-1:`DWD_SER_ADDR_LSB];
            sel  = i_ser_frame[`DWD_SER_ADDR_LSB-1:`DWD_SER_SEL_LSB];
            data = i_ser_frame[`DWD_SER_SEL_LSB-1:0];
        end
    end

    dwd_addr_decode u_dec
    (
        .i_addr      (addr),
        .o_chan_mask (mask)
    );

    assign is_reset = wv && sel == `DWD_SEL_SPECIAL
                      && data == `DWD_SOFT_RESET;
    assign is_step  = wv && sel == `DWD_SEL_SPECIAL && !is_reset;

    // saturating step; 15-bit sum catches overflow, compare before subtract catches underflow
    function [DATA_W-1:0] step_code;
        input [DATA_W-1:0] code;
        input [6:0]        mag;
        input              up;
        reg   [DATA_W:0]   sum;
        begin
            sum = {1'b0, code};
            if (up)
            begin
                sum = sum + {8'h00, mag};
                if (sum > `DWD_FULL_SCALE)
                    sum = `DWD_FULL_SCALE;
            end
            else if ({8'h00, mag} > sum)
                sum = 15'h0000;
            else
                sum = sum - {8'h00, mag};
            step_code = sum[DATA_W-1:0];
        end
    endfunction

    // derived code only as a plain mirror; calibration math lives outside
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            for (c = 0; c < CHAN_N; c = c + 1)
            begin
                input_q[c]   <= `DWD_INPUT_RST;
                offset_q[c]  <= `DWD_OFFSET_RST;
                gain_q[c]    <= `DWD_GAIN_RST;
                derived_q[c] <= `DWD_INPUT_RST;
            end
        end
        else if (is_reset)
        begin
            for (c = 0; c < CHAN_N; c = c + 1)
            begin
                input_q[c]   <= `DWD_INPUT_RST;
                offset_q[c]  <= `DWD_OFFSET_RST;
                gain_q[c]    <= `DWD_GAIN_RST;
                derived_q[c] <= `DWD_INPUT_RST;
            end
        end
        else if (wv)
        begin
            for (c = 0; c < CHAN_N; c = c + 1)
            begin
                if (mask[c])
                begin
                    if (sel == `DWD_SEL_INPUT)
                    begin
                        input_q[c]   <= data;
                        derived_q[c] <= data;
                    end
                    else if (sel == `DWD_SEL_OFFSET)
                        offset_q[c] <= data;
                    else if (sel == `DWD_SEL_GAIN)
                        gain_q[c] <= data;
                    else if (is_step)
                    begin
                        input_q[c] <= step_code(input_q[c],
                            data[`DWD_STEP_MSB:`DWD_STEP_LSB],
                            data[`DWD_DIR_BIT]);
                        derived_q[c] <= step_code(input_q[c],
                            data[`DWD_STEP_MSB:`DWD_STEP_LSB],
                            data[`DWD_DIR_BIT]);
                    end
                end
            end
        end
    end

    // strobes and readback, all registered
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_input_wr             <= {CHAN_N{1'b0}};
            o_offset_wr            <= {CHAN_N{1'b0}};
            o_gain_wr              <= {CHAN_N{1'b0}};
            o_soft_reset           <= 1'b0;
            o_reference_ground     <= 1'b1;
            o_channel_input_code   <= `DWD_INPUT_RST;
            o_offset_code          <= `DWD_OFFSET_RST;
            o_gain_code            <= `DWD_GAIN_RST;
            o_derived_channel_code <= `DWD_INPUT_RST;
        end
        else
        begin
            o_input_wr   <= (wv && (sel == `DWD_SEL_INPUT || is_step))
                            ? mask : {CHAN_N{1'b0}};
            o_offset_wr  <= (wv && sel == `DWD_SEL_OFFSET)
                            ? mask : {CHAN_N{1'b0}};
            o_gain_wr    <= (wv && sel == `DWD_SEL_GAIN)
                            ? mask : {CHAN_N{1'b0}};
            o_soft_reset <= is_reset;
            // outputs stay grounded until the next input write
            if (is_reset)
                o_reference_ground <= 1'b1;
            else if (wv && sel == `DWD_SEL_INPUT)
                o_reference_ground <= 1'b0;
            o_channel_input_code   <= input_q[i_rd_chan];
            o_offset_code          <= offset_q[i_rd_chan];
            o_gain_code            <= gain_q[i_rd_chan];
            o_derived_channel_code <= derived_q[i_rd_chan];
        end
    end
endmodule

/* bench/dwd_host.sv */
// host model: one write word per call, parallel or serial frame
module dwd_host
(
    // clock
    input  wire logic        i_clk,
    // write word toward the decoder
    output logic             o_wr_valid,
    output logic [7:0]       o_addr,
    output logic             o_sel_hi,
    output logic             o_sel_lo,
    output logic [13:0]      o_data,
    output logic             o_ser_valid,
    output logic [23:0]      o_ser_frame
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {o_wr_valid, o_ser_valid, o_addr, o_data, o_ser_frame} = '0;
    initial {o_sel_hi, o_sel_lo} = 2'h0;
    task automatic send(input logic [23:0] w, input logic ser);
        @(posedge i_clk) #1;
        if (ser)
            {o_ser_frame, o_ser_valid} = {w, 1'b1};
        else
            {o_addr, o_sel_hi, o_sel_lo, o_data, o_wr_valid} = {w, 1'b1};
        @(posedge i_clk) #1;
        {o_wr_valid, o_ser_valid} = 2'h0;
        // released address, data and frame lines show the inverse so no stale word looks valid
        {o_addr, o_data, o_ser_frame} = ~{o_addr, o_data, o_ser_frame};
    endtask
endmodule

/* bench/dwd_props.sv */
// assertions on the write word decoder ports
module dwd_props
(
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        i_wr_valid,
    input wire logic        i_ser_valid,
    input wire logic [7:0]  i_write_address_bits,
    input wire logic        i_reg_select_hi,
    input wire logic        i_reg_select_lo,
    input wire logic [13:0] i_write_data_bits,
    input wire logic [31:0] o_input_wr,
    input wire logic [31:0] o_offset_wr,
    input wire logic [31:0] o_gain_wr,
    input wire logic        o_soft_reset,
    input wire logic        o_reference_ground
);
    wire       pw = i_wr_valid && !i_ser_valid;
    wire [1:0] sl = {i_reg_select_hi, i_reg_select_lo};
    wire [3:0] gp = i_write_address_bits[7:4];
    wire [3:0] sc = i_write_address_bits[3:0];
    wire       nw = pw && sl == 2'h3;
    wire [95:0] mk = {o_input_wr, o_offset_wr, o_gain_wr};
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    soft_pulse_a: assert property (pw && sl == 2'h0 &&
        i_write_data_bits == 14'h3FFF |=> o_soft_reset) else $error("no soft");
    ground_hold_a: assert property (o_soft_reset |-> o_reference_ground)
        else $error("ground low at soft reset");
    all_chan_a: assert property (nw && gp == 4'h0 |=> &o_input_wr)
        else $error("broadcast mask wrong");
    bad_slot_a: assert property (pw && gp != 4'h0 &&
        sc inside {[4'h6:4'h7], [4'hA:4'hF]} |=> mk == '0) else $error("bad");
    offset_only_a: assert property (pw && sl == 2'h2 |=>
        o_input_wr == '0 && o_gain_wr == '0) else $error("offset leak");
    gain_all_a: assert property (pw && sl == 2'h1 && gp == 4'h0 |=>
        &o_gain_wr) else $error("gain mask wrong");
    quiet_a: assert property (!i_wr_valid && !i_ser_valid |=>
        mk == '0 && !o_soft_reset) else $error("strobe without write");
    slot_map_a: assert property (nw && gp == 4'h1 && sc < 4'h6 |=>
        o_input_wr == 32'h1 << $past(sc)) else $error("slot map wrong");
    ground_clear_a: assert property (nw && gp == 4'h0 |=>
        !o_reference_ground) else $error("ground stays high");
    cover property (o_soft_reset);
    cover property (pw && sl == 2'h0 && i_write_data_bits[8]);
    cover property (i_ser_valid);
endmodule
bind dwd_decoder dwd_props i_dwd_props(.*);

/* bench/testbench.sv */
// self-checking bench for the write word decoder
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk = 0, i_reset_n = 0;
    logic        i_wr_valid, i_ser_valid, i_reg_select_hi, i_reg_select_lo;
    logic [7:0]  i_write_address_bits;
    logic [13:0] i_write_data_bits, o_channel_input_code, o_offset_code;
    logic [13:0] o_gain_code, o_derived_channel_code;
    logic [23:0] i_ser_frame;
    logic [4:0]  i_rd_chan = 0;
    logic [31:0] o_input_wr, o_offset_wr, o_gain_wr;
    logic        o_soft_reset, o_reference_ground;
    logic [95:0] q[$];
    logic [41:0] st[7] = '{{14'h3F80, 14'h017F, 14'h3FFF},
        {14'h0010, 14'h007F, 14'h0000}, {14'h1234, 14'h0100, 14'h1234},
        {14'h1234, 14'h0000, 14'h1234}, {14'h1234, 14'h0105, 14'h1239},
        {14'h3FF0, 14'h017F, 14'h3FFF}, {14'h1234, 14'h0005, 14'h122F}};
    int          n_errors = 0, n_compared = 0;
    always #4 i_clk = ~i_clk;
    dwd_host i_dwd_host(.i_clk(i_clk), .o_wr_valid(i_wr_valid),
        .o_addr(i_write_address_bits), .o_sel_hi(i_reg_select_hi),
        .o_sel_lo(i_reg_select_lo), .o_data(i_write_data_bits),
        .o_ser_valid(i_ser_valid), .o_ser_frame(i_ser_frame));
    dwd_decoder i_dwd_decoder(.*);
    task automatic chk(input logic [95:0] g, e);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic [31:0] emask(input logic [7:0] a);
        logic [2:0] s;
        s = (a[3:0] > 4'h7) ? a[2:0] + 3'h6 : a[2:0];
        emask = (a[7:4] == 4'h0) ? '1 : '0;
        for (int g = 0; g < 4; g++)
            if (a[4+g])
                emask[g*8+s] = 1'b1;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [1:0] s,
                      input logic [13:0] d, input logic ser = 0);
        logic [31:0] m;
        m = emask(a);
        q.push_back({(s[1] ~^ s[0]) ? m : '0, (s == 2'h2) ? m : '0,
                     (s == 2'h1) ? m : '0});
        i_dwd_host.send({a, s, d}, ser);
    endtask
    task automatic rb(input logic [4:0] c, input logic [13:0] ei, eo, eg);
        @(posedge i_clk) #1 i_rd_chan = c;
        repeat (2) @(posedge i_clk);
        #1 chk({ei, eo, eg, ei}, {o_channel_input_code, o_offset_code,
               o_gain_code, o_derived_channel_code});
    endtask
    task automatic results;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // an unclaimed strobe compares against zero and so fails
    always @(posedge i_clk)
    begin
        #2;
        if ((|{o_input_wr, o_offset_wr, o_gain_wr}) && o_soft_reset !== 1)
            chk({o_input_wr, o_offset_wr, o_gain_wr},
                q.size() ? q.pop_front() : '0);
    end
    initial
    begin
        int s;
        logic [13:0] d;
        void'($urandom(88534));
        repeat (4) @(posedge i_clk);
        #1 i_reset_n = 1;
        chk(o_reference_ground, 1);
        rb(5'd9, 14'h0000, 14'h2000, 14'h3FFF);
        for (int g = 0; g < 16; g++)
        begin
            s = $urandom_range(0, 7);
            d = $urandom;
            wr({g[3:0], s > 5 ? s[3:0] + 4'h2 : s[3:0]}, 2'h3, d, g[0]);
            rb({g[0] ? 2'd0 : g[1] ? 2'd1 : g[2] ? 2'd2 : 2'd3, s[2:0]},
               d, 14'h2000, 14'h3FFF);
        end
        wr(8'h15, 2'h3, d);
        chk(o_reference_ground, 0);
        wr(8'h23, 2'h2, 14'h3FFF);
        wr(8'h23, 2'h1, 14'h0000);
        wr(8'h03, 2'h1, 14'h0000);
        foreach (st[i])
        begin
            wr(8'h23, 2'h3, st[i][41:28]);
            wr(8'h23, 2'h0, st[i][27:14]);
            rb(5'd11, st[i][13:0], 14'h3FFF, 14'h0000);
        end
        i_dwd_host.send({8'h27, 2'h3, 14'h0ABC}, 0);
        i_dwd_host.send({8'h2C, 2'h1, 14'h0ABC}, 1);
        rb(5'd11, 14'h122F, 14'h3FFF, 14'h0000);
        i_dwd_host.send({8'h23, 2'h0, 14'h3FFF}, 0);
        chk(o_soft_reset, 1);
        rb(5'd11, 14'h0000, 14'h2000, 14'h3FFF);
        chk(o_reference_ground, 1);
        chk(q.size(), 0);
        results;
    end
    initial
    begin
        #100000;
        n_errors++;
        results;
    end
endmodule
